// ==== rtl/serial_pkg.sv ====
// Purpose: Shared constants for the three-wire serial master channel
// Assumes: sys_clk at 40 MHz, AXI4-Lite register access
// Notes:   Offsets are byte addresses of 32-bit registers
package serial_pkg;
  // ==========================================================
  // Clocking and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SCLK_HZ         = 312_500;
  localparam int unsigned SCLK_HALF       = CLK_HZ / (2 * SCLK_HZ);
  localparam logic [5:0]  HALF_LAST       = 6'(SCLK_HALF - 1);
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES_DEF = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned XFER_BITS       = 8;
  localparam logic [2:0]  LAST_BIT        = 3'(XFER_BITS - 1);
  localparam logic [10:0] XFER_CYCLES     = 11'(2 * XFER_BITS * SCLK_HALF);

  // ==========================================================
  // Bus
  localparam int unsigned ADDR_W     = 8;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_ISTAT  = 8'h0C;
  localparam logic [7:0] OFF_IMASK  = 8'h10;

  // Interrupt status bit positions
  localparam int unsigned EV_END  = 0;
  localparam int unsigned EV_FALL = 1;
  localparam int unsigned EV_TICK = 2;
  localparam int unsigned EV_SKIP = 3;
  localparam int unsigned EV_N    = 4;

  // ==========================================================
  // Data and reset values
  localparam logic [7:0]      TX_FIRST   = 8'h05;
  localparam logic [7:0]      TX_SECOND  = 8'h50;
  localparam logic [7:0]      DATA_RST   = 8'h00;
  localparam logic [EV_N-1:0] IMASK_RST  = 4'h0;
  localparam logic            AUTO_RST   = 1'b0;
endpackage

// ==== rtl/sync_edge.sv ====
// Purpose: Two-flop synchroniser with edge detection
// Assumes: async_in is from outside the sys_clk domain
// Notes:   First flop feeds only the second flop
`timescale 1ns/1ps
module sync_edge #(
  parameter logic INIT = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic prev;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta  <= INIT;
      level <= INIT;
      prev  <= INIT;
    end else begin
      meta  <= async_in;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

// ==== rtl/shift_engine.sv ====
// Purpose: Full-duplex 8-bit shifter with serial clock divider
// Assumes: sdi already synchronised to sys_clk
// Notes:   Clock idles high; data out on falling, in on rising edge
`timescale 1ns/1ps
module shift_engine (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sdi,
  output logic            sclk,
  output logic            sdo,
  output logic            active,
  output logic            done,
  output logic [7:0]      rx_byte
);
  import serial_pkg::*;

  logic [5:0]  half_cnt;
  logic [2:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [10:0] xfer_len;

  wire half_end = active && (half_cnt == HALF_LAST);
  wire fall_now = half_end && sclk;
  wire rise_now = half_end && !sclk;
  wire last_now = rise_now && (bit_cnt == LAST_BIT);

  // divider gives the serial clock rate
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      half_cnt <= 6'h00;
    end else if (start || half_end) begin
      half_cnt <= 6'h00;
    end else if (active) begin
      half_cnt <= half_cnt + 6'h01;
    end
  end

  // MSB first, 8 bits per transfer
  // one bit out and one bit in per clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active  <= 1'b0;
      sclk    <= 1'b1;
      sdo     <= 1'b1;
      bit_cnt <= 3'h0;
      shreg   <= 8'h00;
      done    <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        active  <= 1'b1;
        bit_cnt <= 3'h0;
        shreg   <= tx_byte;
      end else if (fall_now) begin
        // type 1 phase, data leads on falling edge
        sclk <= 1'b0;
        sdo  <= shreg[7];
      end else if (rise_now) begin
        // sample receive bit on rising edge
        sclk    <= 1'b1;
        shreg   <= {shreg[6:0], sdi};
        bit_cnt <= bit_cnt + 3'h1;
        if (last_now) begin
          active  <= 1'b0;
          done    <= 1'b1;
          rx_byte <= {shreg[6:0], sdi};
          sdo     <= 1'b1;
        end
      end
    end
  end

  // Helper: cycles since start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      xfer_len <= 11'h000;
    end else if (start && !active) begin
      xfer_len <= 11'h000;
    end else if (active) begin
      xfer_len <= xfer_len + 11'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  half_period_a: assert property ($changed(sclk) |-> $past(half_cnt) == HALF_LAST)
    else $error("serial clock half period wrong");
  idle_high_a: assert property (!active && !$past(active) |-> sclk && sdo)
    else $error("serial lines not idle high");
  xfer_len_a: assert property ($rose(done) |-> xfer_len == XFER_CYCLES)
    else $error("transfer length wrong");
  data_edge_a: assert property (active && $changed(sdo) |-> $fell(sclk))
    else $error("transmit data changed off falling edge");
  rx_capture_a: assert property (rise_now |=> shreg[0] == $past(sdi))
    else $error("receive bit not captured on rising edge");
endmodule

// ==== rtl/three_wire_master.sv ====
// Purpose: Three-wire serial master channel with busy handshake
// Assumes: AXI4-Lite master, slave gives busy level on slave_busy
// Notes:   Transfers start from software or from the interval tick
//
// Operation
// - Auto mode sends 0x05 and 0x50 in turn, receiving a byte each time.
// - A data buffer write loads the shifter and starts the serial clock.
// - At the end the received byte goes to the data buffer and the end event is set in the same cycle.
// - A transfer starts only when idle and the slave is not busy, else skipped.
// - Auto transfers wait for a busy falling edge since the last launch.
// - Busy edges are caught by edge-detect logic, not by polling.
// - The serial clock runs near 312.5 kHz, divided from the system clock.
// - Every single byte transfer raises the end event once.
// - Phase type 1 sets the data to clock relation.
// - Each transfer moves 8 bits, MSB first.
// - Serial clock and data out idle at 1.
// - Both directions move together, one bit each per clock.
// - Auto attempts are paced by a 10 ms interval tick.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module three_wire_master #(
  parameter int unsigned TICK_CYCLES = serial_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  input  wire logic [serial_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [serial_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               serial_clock_out,
  output logic                               serial_data_out,
  input  wire logic                          serial_data_in,
  input  wire logic                          slave_busy,
  output logic                               irq
);
  import serial_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic busy_lvl;
  logic busy_fall;
  logic sdi_lvl;

  // hardware edge detection of the busy line
  // Resets to the idle low level, so release fakes no falling edge
  sync_edge #(.INIT(1'b0)) u_busy_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (slave_busy),
    .level    (busy_lvl),
    .rise     (),
    .fall     (busy_fall)
  );

  sync_edge #(.INIT(1'b1)) u_sdi_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (serial_data_in),
    .level    (sdi_lvl),
    .rise     (),
    .fall     ()
  );

  // ==========================================================
  // Interval tick
  logic [31:0] tick_cnt;
  logic        tick;

  // Runs regardless of auto mode, ticks still raise their event
  // periodic attempt tick
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  // Register effect one cycle after both halves are taken
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [ADDR_W-1:0] wa = {aw_addr[ADDR_W-1:2], 2'b00};
  wire wr_ctrl  = do_write && w_strb[0] && (wa == OFF_CTRL);
  wire wr_data  = do_write && w_strb[0] && (wa == OFF_DATA);
  wire wr_istat = do_write && w_strb[0] && (wa == OFF_ISTAT);
  wire wr_imask = do_write && w_strb[0] && (wa == OFF_IMASK);
  wire wa_hit   = (wa == OFF_CTRL) || (wa == OFF_DATA) || (wa == OFF_STATUS) ||
                  (wa == OFF_ISTAT) || (wa == OFF_IMASK);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Channel control
  logic            auto_en;
  logic            armed;
  logic            pattern_sel;
  logic [7:0]      data_buf;
  logic [EV_N-1:0] ist;
  logic [EV_N-1:0] imask;
  logic            eng_busy;
  logic            eng_done;
  logic [7:0]      rx_byte;

  // launch only when idle and slave not busy
  wire can_go   = !eng_busy && !busy_lvl;
  wire auto_try = tick && auto_en && !wr_data;
  // auto launch needs a busy falling edge since last launch
  wire auto_go  = auto_try && armed && can_go;
  wire sw_go    = wr_data && can_go;
  wire start    = sw_go || auto_go;
  wire [7:0] auto_byte = pattern_sel ? TX_SECOND : TX_FIRST;
  wire [7:0] tx_byte   = sw_go ? w_data[7:0] : auto_byte;
  wire skip_ev  = (wr_data && !can_go) || (auto_try && !(armed && can_go));

  wire [EV_N-1:0] events;
  assign events[EV_END]  = eng_done;
  assign events[EV_FALL] = busy_fall;
  assign events[EV_TICK] = tick;
  assign events[EV_SKIP] = skip_ev;

  wire [EV_N-1:0] ist_clr  = wr_istat ? w_data[EV_N-1:0] : '0;
  // New event wins over a same-cycle clear
  wire [EV_N-1:0] next_ist = (ist & ~ist_clr) | events;
  wire            irq_src  = |(ist & imask);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      auto_en     <= AUTO_RST;
      imask       <= IMASK_RST;
      ist         <= '0;
      irq         <= 1'b0;
      armed       <= 1'b1;
      pattern_sel <= 1'b0;
    end else begin
      if (wr_ctrl)
        auto_en <= w_data[0];
      if (wr_imask)
        imask <= w_data[EV_N-1:0];
      ist   <= next_ist;
      irq   <= irq_src;
      // A launch drops armed unless busy falls in that cycle, auto then waits for a fresh busy fall
      armed <= busy_fall || (armed && !start);
      if (auto_go)
        pattern_sel <= !pattern_sel;
    end
  end

  // received byte replaces the transmit byte in the buffer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      data_buf <= DATA_RST;
    end else if (eng_done) begin
      data_buf <= rx_byte;
    end else if (start) begin
      data_buf <= tx_byte;
    end
  end

  shift_engine u_engine (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (start),
    .tx_byte (tx_byte),
    .sdi     (sdi_lvl),
    .sclk    (serial_clock_out),
    .sdo     (serial_data_out),
    .active  (eng_busy),
    .done    (eng_done),
    .rx_byte (rx_byte)
  );

  // ==========================================================
  // AXI4-Lite read channel
  wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire ra_hit = (ra == OFF_CTRL) || (ra == OFF_DATA) || (ra == OFF_STATUS) ||
                (ra == OFF_ISTAT) || (ra == OFF_IMASK);
  wire [31:0] rd_ctrl   = {31'h0, auto_en};
  wire [31:0] rd_data   = {24'h0, data_buf};
  wire [31:0] rd_status = {28'h0, pattern_sel, armed, busy_lvl, eng_busy};
  wire [31:0] rd_istat  = {28'h0, ist};
  wire [31:0] rd_imask  = {28'h0, imask};
  wire [31:0] rd_mux =
    (ra == OFF_CTRL)   ? rd_ctrl :
    (ra == OFF_DATA)   ? rd_data :
    (ra == OFF_STATUS) ? rd_status :
    (ra == OFF_ISTAT)  ? rd_istat :
    (ra == OFF_IMASK)  ? rd_imask : 32'h0000_0000;

  // Read data frozen at the address handshake
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= ra_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence launch_s;
    $rose(eng_busy);
  endsequence

  sequence auto_launch_s;
    launch_s ##0 !$past(wr_data);
  endsequence

  sequence refused_s;
    wr_data && !can_go;
  endsequence

  skip_flag_a: assert property (refused_s |=> ist[EV_SKIP])
    else $error("refused start not flagged");
  tick_event_a: assert property (tick |=> ist[EV_TICK])
    else $error("interval tick not flagged");

  launch_gate_a: assert property (launch_s |-> !$past(busy_lvl))
    else $error("transfer launched while slave busy");
  sw_launch_a: assert property (wr_data && can_go |=> eng_busy && data_buf == 8'($past(w_data)))
    else $error("buffer write did not start transfer");
  rx_store_a: assert property (eng_done |=> data_buf == $past(rx_byte) && ist[EV_END])
    else $error("received byte not stored with end event");
  auto_arm_a: assert property (auto_launch_s |-> $past(armed) && $past(tick))
    else $error("auto launch without busy fall and tick");
  fall_arm_a: assert property (busy_fall |=> armed)
    else $error("busy falling edge not recorded");
  alternate_a: assert property (auto_launch_s |-> pattern_sel != $past(pattern_sel) &&
                                data_buf == ($past(pattern_sel) ? TX_SECOND : TX_FIRST))
    else $error("auto byte did not alternate");
  end_event_a: assert property ($rose(ist[EV_END]) |-> $past(eng_done))
    else $error("end event without completed transfer");
  tick_space_a: assert property (tick |=> (!tick)[*8])
    else $error("interval tick repeated too soon");
  irq_follow_a: assert property (##1 irq == $past(irq_src))
    else $error("interrupt line does not follow masked status");
endmodule

// ==== tb/busy_slave_model.sv ====
// Purpose: Slave side of the three-wire link with a busy line
// Assumes: Master clock idles high, 8-bit MSB-first frames
// Notes:   Data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
module busy_slave_model (
  input  wire logic        sys_clk,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic [7:0]  next_byte,
  input  wire logic [15:0] hold_cycles,
  input  wire logic        busy_req,
  output logic             miso,
  output logic             busy,
  output logic [7:0]       got_byte
);
  logic [7:0] sh;
  logic [7:0] rx;
  logic       mosi_d;
  logic       busy_int;

  assign busy = busy_int | busy_req;

  // Mid-cycle copy, so the last bit never races the idle level
  always @(negedge sys_clk) mosi_d <= mosi;

  initial begin
    miso     = 1'b0;
    busy_int = 1'b0;
    got_byte = 8'h00;
    @(posedge sys_clk);
    sh = next_byte;
    forever begin
      @(negedge sclk);
      // bit out on fall, in on rise
      for (int i = 0; i < 8; i++) begin
        if (i > 0) @(negedge sclk);
        miso <= sh[7];
        @(posedge sclk);
        rx = {rx[6:0], mosi_d};
        sh = {sh[6:0], 1'b0};
      end
      got_byte <= rx;
      miso     <= ~miso;
      // busy held until next byte ready
      busy_int <= 1'b1;
      repeat (hold_cycles) @(posedge sys_clk);
      sh = next_byte;
      busy_int <= 1'b0;
    end
  end
endmodule

// ==== tb/three_wire_master_test.sv ====
// Purpose: Self-checking bench for the three-wire serial master
// Assumes: Register map and timing from the design package
// Notes:   Short interval tick keeps the run brief
`timescale 1ns/1ps
module three_wire_master_test;
  import serial_pkg::*;
  localparam int unsigned TICKS = 3000;
  logic        sys_clk, resetn, busy_req, sclk_q;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, next_byte, got_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        serial_clock_out, serial_data_out, serial_data_in, slave_busy, irq;
  logic [15:0] hold_cycles, low_len;
  logic [15:0] low_run = 16'h0000;
  int          bad_count = 0, total_checks = 0, fall_count = 0, cyc = 0, base;

  three_wire_master #(.TICK_CYCLES(TICKS)) three_wire_master_inst (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
    .serial_data_in(serial_data_in), .slave_busy(slave_busy), .irq(irq));

  busy_slave_model busy_slave_model_inst (
    .sys_clk(sys_clk), .sclk(serial_clock_out), .mosi(serial_data_out), .next_byte(next_byte),
    .hold_cycles(hold_cycles), .busy_req(busy_req), .miso(serial_data_in), .busy(slave_busy),
    .got_byte(got_byte));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Serial clock watcher and hang guard
  always @(posedge sys_clk) begin
    sclk_q <= serial_clock_out;
    if (sclk_q && !serial_clock_out) fall_count++;
    if (!serial_clock_out) low_run <= low_run + 16'h0001;
    else begin
      if (low_run != 16'h0000) low_len <= low_run;
      low_run <= 16'h0000;
    end
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      $display("FAIL timeout expected 0 seen %0d", cyc);
      print_verdict();
    end
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    s_axi_awaddr  <= addr;
    s_axi_wdata   <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, resp);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic axi_read(input logic [7:0] addr, input logic [1:0] resp);
    s_axi_araddr  <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_val = s_axi_rdata;
    check("rresp", s_axi_rresp, resp);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic expect_reg(input string name, input logic [7:0] addr, input logic [31:0] mask,
                            input logic [31:0] exp);
    axi_read(addr, RESP_OKAY);
    check(name, rd_val & mask, exp);
  endtask

  task automatic wait_irq(input int limit);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < limit) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {resetn, busy_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    next_byte   = 8'hA6;
    hold_cycles = 16'h0014;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    check("sclk idle", serial_clock_out, 32'h1);
    check("sdo idle", serial_data_out, 32'h1);
    repeat (3) @(posedge sys_clk);
    expect_reg("status rst", OFF_STATUS, 32'hF, 32'h4);
    axi_read(8'h14, RESP_SLVERR);
    check("unmapped rd", rd_val, 32'h0);
    axi_write(8'h20, 32'h1, RESP_SLVERR);
    axi_write(OFF_IMASK, 32'h1, RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    axi_write(OFF_IMASK, 32'hF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    expect_reg("strobe off", OFF_IMASK, 32'hF, 32'h1);
    // Software start, then a refused start while active
    base = fall_count;
    axi_write(OFF_DATA, 32'h3C, RESP_OKAY);
    expect_reg("data in flight", OFF_DATA, 32'hFF, 32'h3C);
    expect_reg("active", OFF_STATUS, 32'h1, 32'h1);
    axi_write(OFF_DATA, 32'h11, RESP_OKAY);
    wait_irq(1500);
    check("irq end", irq, 32'h1);
    check("slave got", got_byte, 32'h3C);
    check("clock falls", fall_count - base, XFER_BITS);
    check("low phase", low_len, SCLK_HALF);
    check("sdo back idle", serial_data_out, 32'h1);
    expect_reg("rx byte", OFF_DATA, 32'hFF, 32'hA6);
    expect_reg("end and skip", OFF_ISTAT, 32'h9, 32'h9);
    axi_write(OFF_ISTAT, 32'hF, RESP_OKAY);
    repeat (200) @(posedge sys_clk);
    check("irq once", irq, 32'h0);
    // Busy slave refuses a start
    busy_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    expect_reg("busy seen", OFF_STATUS, 32'h2, 32'h2);
    axi_write(OFF_DATA, 32'h77, RESP_OKAY);
    expect_reg("no start", OFF_STATUS, 32'h1, 32'h0);
    expect_reg("skip flag", OFF_ISTAT, 32'h8, 32'h8);
    busy_req <= 1'b0;
    repeat (5) @(posedge sys_clk);
    axi_write(OFF_ISTAT, 32'hF, RESP_OKAY);
    // Short busy pulse still seen
    busy_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    busy_req <= 1'b0;
    repeat (5) @(posedge sys_clk);
    expect_reg("pulse edge", OFF_ISTAT, 32'h2, 32'h2);
    // Auto mode, slow slave forces two skipped ticks
    next_byte   <= 8'hC3;
    hold_cycles <= 16'h1388;
    axi_write(OFF_CTRL, 32'h1, RESP_OKAY);
    axi_write(OFF_ISTAT, 32'hF, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      wait_irq(10000);
      check("auto irq", irq, 32'h1);
      check("auto byte", got_byte, k == 0 ? TX_FIRST : TX_SECOND);
      expect_reg("auto rx", OFF_DATA, 32'hFF, k == 0 ? 32'hA6 : 32'hC3);
      expect_reg("tick skip", OFF_ISTAT, 32'h8, k == 0 ? 32'h0 : 32'h8);
      axi_write(OFF_ISTAT, 32'hF, RESP_OKAY);
    end
    axi_write(OFF_CTRL, 32'h0, RESP_OKAY);
    expect_reg("pattern wrap", OFF_STATUS, 32'h8, 32'h0);
    print_verdict();
  end
endmodule
